// file: verilog/rpq_core.v
/*
 * Read pulse qualifier and data separator: transition flop, output
 * one-shot, address mark mode, phase detector steering, oscillator stop
 * control and strobe skewing, with a FIFO on the clocked data path.
 * Assumes every input is synchronous to the 200 MHz clock; the analogue
 * channels arrive as sampled levels and the oscillators as sampled levels.
 */
`timescale 1ns/1ps
`include "rpq_defs.vh"

module rpq_core (
	input  wire                  clock,
	input  wire                  rst_n,
	input  wire                  clk_en,
	input  wire                  write_enable_n,
	input  wire                  low_res,
	input  wire                  high_res_clk,
	input  wire                  tag_ctrl,
	input  wire [`RPQ_BUS_W-1:0] ctrl_bus,
	input  wire                  double_rate_read_osc,
	input  wire                  write_side_reference,
	input  wire                  data_ready,
	output wire                  read_pulse,
	output reg                   address_mark_gate_n,
	output reg                   read_gate_r,
	output reg                   pump_up,
	output reg                   pump_down,
	output reg                   osc_stop,
	output reg                   locked,
	output reg                   read_clock_out,
	output wire                  clocked_data,
	output wire                  data_valid,
	output wire                  fifo_ready,
	output reg                   strobe_early_r,
	output reg                   strobe_late_r
);
	// Counter loads, one less than each length since the count ends at zero;
	// they are cut to the counter widths where they are used.
	localparam integer STOP_N = `RPQ_STOP_CYC - 1;  // Stop interval load.
	localparam integer LOCK_N = `RPQ_LOCK_CYC - 1;  // Relock interval load.
	localparam integer PDN_N  = `RPQ_PDN_CYC - 1;   // Pump-down load.

	reg                 transition_flop;     // Qualified transition state.
	reg                 hr_q_r;              // Previous high-res level.
	reg                 lr_q_r;              // Previous low-res level.
	reg                 osc_q_r;             // Previous oscillator level.
	reg                 ref_q_r;             // Previous reference level.
	reg                 rg_q_r;              // Read gate last cycle.
	reg                 gate_chg_r;          // Gate changed, awaiting a pulse.
	reg [`RPQ_CNT_W-1:0] stop_cnt_r;         // Stop interval left.
	reg [`RPQ_CNT_W-1:0] lock_cnt_r;         // Relock interval left.
	reg                 pup_wait_r;          // Pump-up waiting for osc edge.
	reg [1:0]           pdn_cnt_r;           // Pump-down cycles left.
	reg                 ref_lead_r;          // Reference edge seen first.
	reg                 osc_lead_r;          // Oscillator edge seen first.
	reg                 mode_q_r;            // Previous loop mode.
	reg [1:0]           dly_r;               // Delay taps for skewing.
	wire                hr_rise;
	wire                lr_edge;
	wire                osc_rise;
	wire                ref_rise;
	wire                path_on;
	wire                amark;
	wire                trig;
	wire                qpulse;
	wire                read_mode;
	wire                early_eff;
	wire                late_eff;
	wire                data_src;
	wire                ldummy_mode;         // Read-mode flag of the FIFO head word.
	wire                clocked_data_w;      // Data bit of the FIFO head word.

	// Decodes one bus bit from a control-select command.
	function tag_bit;
		input                  t;
		input [`RPQ_BUS_W-1:0] b;
		input integer          n;
		begin
			tag_bit = t & b[n];
		end
	endfunction

	// Edge detectors on the sampled pin levels, one cycle of history each.
	assign hr_rise  = high_res_clk & ~hr_q_r;
	assign lr_edge  = low_res ^ lr_q_r;
	assign osc_rise = double_rate_read_osc & ~osc_q_r;
	assign ref_rise = write_side_reference & ~ref_q_r;
	// Mark search is the inverse of the active-low gate.
	assign amark    = ~address_mark_gate_n;
	assign path_on  = write_enable_n & read_gate_r;
	// Normal mode fires on flop changes; mark mode fires on low-res edges.
	assign trig     = path_on & (amark ? lr_edge
	                                   : (hr_rise & (low_res != transition_flop)));
	// The loop reads only with the gate up and no mark search; both strobe
	// bits together fall back to nominal so only one path is ever delayed.
	assign read_mode = read_gate_r & ~amark;
	assign early_eff = strobe_early_r & ~strobe_late_r;
	assign late_eff  = strobe_late_r & ~strobe_early_r;

	// The output one-shot gives a fixed-width pulse per qualified transition.
	rpq_pulse #(
		.LEN (`RPQ_PULSE_CYC),
		.CW  (`RPQ_CNT_W)
	) u_shot (
		.clock  (clock),
		.rst_n  (rst_n),
		.clk_en (clk_en),
		.trig   (trig),
		.pulse  (qpulse)
	);
	// The qualified pulse leaves the block straight from the one-shot's flop.
	assign read_pulse = qpulse;

	// Control-select commands latch read, mark search and strobe bits.
	always @(posedge clock) begin
		if (!rst_n) begin
			read_gate_r         <= 1'b0;
			address_mark_gate_n <= 1'b1;
			strobe_early_r      <= 1'b0;
			strobe_late_r       <= 1'b0;
		end else if (clk_en && tag_ctrl) begin
			read_gate_r         <= tag_bit(tag_ctrl, ctrl_bus, `RPQ_BIT_READ);
			address_mark_gate_n <= ~(tag_bit(tag_ctrl, ctrl_bus, `RPQ_BIT_READ)
			                       & tag_bit(tag_ctrl, ctrl_bus, `RPQ_BIT_AMARK));
			strobe_early_r      <= tag_bit(tag_ctrl, ctrl_bus, `RPQ_BIT_EARLY);
			strobe_late_r       <= tag_bit(tag_ctrl, ctrl_bus, `RPQ_BIT_LATE);
		end
	end

	// Edge history and the transition flop itself.
	always @(posedge clock) begin
		if (!rst_n) begin
			transition_flop <= 1'b0;
			hr_q_r          <= 1'b0;
			lr_q_r          <= 1'b0;
			osc_q_r         <= 1'b0;
			ref_q_r         <= 1'b0;
		end else if (clk_en) begin
			hr_q_r  <= high_res_clk;
			lr_q_r  <= low_res;
			osc_q_r <= double_rate_read_osc;
			ref_q_r <= write_side_reference;
			// Mark search parks the flop set so only low-res edges fire the one-shot.
			if (amark) begin
				transition_flop <= 1'b1;
			end else if (path_on && hr_rise) begin
				transition_flop <= low_res;
			end
		end
	end

	// Phase detector: quadrature while reading, coincidence while idle.
	always @(posedge clock) begin
		if (!rst_n) begin
			pump_up    <= 1'b0;
			pump_down  <= 1'b0;
			pup_wait_r <= 1'b0;
			pdn_cnt_r  <= 2'h0;
			ref_lead_r <= 1'b0;
			osc_lead_r <= 1'b0;
		end else if (clk_en) begin
			if (osc_stop) begin
				pump_up    <= 1'b0;
				pump_down  <= 1'b0;
				pup_wait_r <= 1'b0;
				pdn_cnt_r  <= 2'h0;
			end else if (read_mode) begin
				ref_lead_r <= 1'b0;
				osc_lead_r <= 1'b0;
				if (trig && !pup_wait_r) begin
					pup_wait_r <= 1'b1;
					pump_up    <= 1'b1;
					pump_down  <= 1'b0;
				end else if (pup_wait_r && osc_rise) begin
					pup_wait_r <= 1'b0;
					pump_up    <= 1'b0;
					pump_down  <= 1'b1;
					pdn_cnt_r  <= PDN_N[1:0];
				end else if (pdn_cnt_r != 2'h0) begin
					// Pump-up follows the wait flag so a level left from idle cannot linger.
					pump_up   <= pup_wait_r;
					pdn_cnt_r <= pdn_cnt_r - 1'b1;
				end else begin
					pump_up   <= pup_wait_r;
					pump_down <= 1'b0;
				end
			end else begin
				pup_wait_r <= 1'b0;
				pdn_cnt_r  <= 2'h0;
				// Lead: reference first, pump up until the oscillator edge.
				if (ref_rise && osc_rise) begin
					ref_lead_r <= 1'b0;
					osc_lead_r <= 1'b0;
				end else if (ref_rise) begin
					if (osc_lead_r) begin
						osc_lead_r <= 1'b0;
					end else begin
						ref_lead_r <= 1'b1;
					end
				end else if (osc_rise) begin
					if (ref_lead_r) begin
						ref_lead_r <= 1'b0;
					end else begin
						osc_lead_r <= 1'b1;
					end
				end
				pump_up   <= ref_lead_r & ~osc_rise;
				pump_down <= osc_lead_r & ~ref_rise;
			end
		end
	end

	// Oscillator stop after the first pulse following a gate change,
	// and a relock window from each loop mode change that reports lock when it ends.
	always @(posedge clock) begin
		if (!rst_n) begin
			rg_q_r     <= 1'b0;
			gate_chg_r <= 1'b0;
			stop_cnt_r <= {`RPQ_CNT_W{1'b0}};
			lock_cnt_r <= {`RPQ_CNT_W{1'b0}};
			osc_stop   <= 1'b0;
			locked     <= 1'b0;
			mode_q_r   <= 1'b0;
		end else if (clk_en) begin
			rg_q_r   <= read_gate_r;
			mode_q_r <= read_mode;
			// A gate change arms the stop; the first pulse after it disarms it.
			if (rg_q_r != read_gate_r) begin
				gate_chg_r <= 1'b1;
			end else if (gate_chg_r && trig) begin
				gate_chg_r <= 1'b0;
			end
			// The countdown runs apart from the arming so a gate change never stalls it.
			if (gate_chg_r && trig && (rg_q_r == read_gate_r)) begin
				osc_stop   <= 1'b1;
				stop_cnt_r <= STOP_N[`RPQ_CNT_W-1:0];
			end else if (stop_cnt_r != {`RPQ_CNT_W{1'b0}}) begin
				stop_cnt_r <= stop_cnt_r - 1'b1;
			end else begin
				osc_stop <= 1'b0;
			end
			if (mode_q_r != read_mode) begin
				lock_cnt_r <= LOCK_N[`RPQ_CNT_W-1:0];
				locked     <= 1'b0;
			end else if (lock_cnt_r != {`RPQ_CNT_W{1'b0}}) begin
				lock_cnt_r <= lock_cnt_r - 1'b1;
			end else begin
				locked <= 1'b1;
			end
		end
	end

	// Strobe skew: data or clock runs through a one-cycle delay tap.
	always @(posedge clock) begin
		if (!rst_n) begin
			dly_r          <= 2'h0;
			read_clock_out <= 1'b0;
		end else if (clk_en) begin
			dly_r          <= {double_rate_read_osc, qpulse};
			read_clock_out <= early_eff ? dly_r[1] : double_rate_read_osc;
		end
	end
	// Late strobe takes the data from the delay tap; early takes the clock instead.
	assign data_src = late_eff ? dly_r[0] : qpulse;

	// While the read gate is up, clocked data is sampled once per oscillator rising edge into the FIFO.
	rpq_fifo #(
		.W  (`RPQ_FIFO_W),
		.D  (`RPQ_FIFO_D),
		.AW (`RPQ_FIFO_AW)
	) u_fifo (
		.clock     (clock),
		.rst_n     (rst_n),
		.clk_en    (clk_en),
		.in_data   ({read_mode, data_src}),
		.in_valid  (osc_rise & read_gate_r),
		.in_ready  (fifo_ready),
		.out_data  ({ldummy_mode, clocked_data_w}),
		.out_valid (data_valid),
		.out_ready (data_ready)
	);
	// Only words pushed in read mode carry data to the output.
	assign clocked_data = clocked_data_w & ldummy_mode;
endmodule // rpq_core

// file: verilog/rpq_defs.vh
/*
 * Constants for the read pulse qualifier and data separator: timing counts,
 * control-select bus bit positions and strobe delay settings.
 * Assumes a 200 MHz system clock (5 ns period) and Verilog-2005 tools.
 */
`ifndef RPQ_DEFS_VH
`define RPQ_DEFS_VH

// System clock period in picoseconds.
`define RPQ_CLK_PS            5000
// Output pulse width in picoseconds, and its count (least time, round up).
`define RPQ_PULSE_PS          20000
`define RPQ_PULSE_CYC         ((`RPQ_PULSE_PS + `RPQ_CLK_PS - 1) / `RPQ_CLK_PS)
// Oscillator stop time in picoseconds and its count (approximate, round down).
`define RPQ_STOP_PS           200000
`define RPQ_STOP_CYC          (`RPQ_STOP_PS / `RPQ_CLK_PS)
// Relock budget in picoseconds and its count (longest time, round down).
`define RPQ_LOCK_PS           2000000
`define RPQ_LOCK_CYC          (`RPQ_LOCK_PS / `RPQ_CLK_PS)
// Fixed pump-down length in cycles while reading.
`define RPQ_PDN_CYC           2
// Strobe delay in picoseconds and its count (at least one cycle).
`define RPQ_SKEW_PS           2900
`define RPQ_SKEW_CYC          1
// Counter widths.
`define RPQ_CNT_W             9
// Control-select bus bit positions (bits numbered from 0 on the port).
`define RPQ_BIT_READ          1
`define RPQ_BIT_AMARK         5
`define RPQ_BIT_EARLY         7
`define RPQ_BIT_LATE          8
`define RPQ_BUS_W             10
// Buffer shape.
`define RPQ_FIFO_W            2
`define RPQ_FIFO_D            16
`define RPQ_FIFO_AW           4

`endif

// file: verilog/rpq_fifo.v
/*
 * Synchronous FIFO with valid/ready on both sides, flip-flop storage.
 * Assumes one clock, a synchronous active-low reset and a clock enable.
 */
`timescale 1ns/1ps
module rpq_fifo #(
	parameter W  = 2,
	parameter D  = 16,
	parameter AW = 4
) (
	input  wire          clock,
	input  wire          rst_n,
	input  wire          clk_en,
	input  wire [W-1:0]  in_data,
	input  wire          in_valid,
	output wire          in_ready,
	output reg  [W-1:0]  out_data,
	output wire          out_valid,
	input  wire          out_ready
);
	reg [W-1:0]  mem_r [0:D-1];   // Storage words.
	reg [AW-1:0] wp_r;            // Write index.
	reg [AW-1:0] rp_r;            // Read index.
	reg [AW:0]   cnt_r;           // Words held.
	wire         push;            // Word accepted this cycle.
	wire         pop;             // Word delivered this cycle.
	integer      i;

	assign in_ready  = (cnt_r != D[AW:0]);
	assign out_valid = (cnt_r != {(AW+1){1'b0}});
	assign push      = clk_en & in_valid & in_ready;
	assign pop       = clk_en & out_valid & out_ready;

	// Read data is taken from the current read index.
	always @* begin
		out_data = mem_r[rp_r];
	end

	// Pointers and count move on accepted pushes and pops.
	always @(posedge clock) begin
		if (!rst_n) begin
			wp_r  <= {AW{1'b0}};
			rp_r  <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
			for (i = 0; i < D; i = i + 1) begin
				mem_r[i] <= {W{1'b0}};
			end
		end else begin
			if (push) begin
				mem_r[wp_r] <= in_data;
				wp_r        <= wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'b1;
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop && !push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule // rpq_fifo

// file: verilog/rpq_pulse.v
/*
 * Retriggerable one-shot: each trigger restarts a fixed-length high pulse.
 * Assumes one clock, a synchronous active-low reset and a clock enable.
 */
`timescale 1ns/1ps
module rpq_pulse #(
	parameter LEN = 4,
	parameter CW  = 9
) (
	input  wire clock,
	input  wire rst_n,
	input  wire clk_en,
	input  wire trig,
	output reg  pulse
);
	reg [CW-1:0] cnt_r;   // Cycles left in the pulse.

	// A trigger loads the length less one; the output stays high while cycles remain.
	always @(posedge clock) begin
		if (!rst_n) begin
			cnt_r <= {CW{1'b0}};
			pulse <= 1'b0;
		end else if (clk_en) begin
			if (trig) begin
				cnt_r <= LEN[CW-1:0] - 1'b1;
				pulse <= 1'b1;
			end else if (cnt_r != {CW{1'b0}}) begin
				cnt_r <= cnt_r - 1'b1;
			end else begin
				pulse <= 1'b0;
			end
		end
	end
endmodule // rpq_pulse

// file: sim/rpq_checker.sv
/* Concurrent checks on the ports of rpq_core: tags, pulse widths, loop controls.
   Assumes the shared constants header and that clk_en high means a live cycle. */
`timescale 1ns/1ps
`include "rpq_defs.vh"
module rpq_checker (
	input wire logic                  clock,
	input wire logic                  rst_n,
	input wire logic                  clk_en,
	input wire logic                  write_enable_n,
	input wire logic                  tag_ctrl,
	input wire logic [`RPQ_BUS_W-1:0] ctrl_bus,
	input wire logic                  read_pulse,
	input wire logic                  address_mark_gate_n,
	input wire logic                  read_gate_r,
	input wire logic                  pump_down,
	input wire logic                  osc_stop,
	input wire logic                  locked,
	input wire logic                  strobe_early_r,
	input wire logic                  strobe_late_r
);
	logic [6:0] stop_cnt_r; // Length of the current stop pulse in cycles.

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n || !clk_en);

	// Counts how long the stop pulse has stood, cleared when it drops.
	always @(posedge clock) begin
		if (!rst_n || !osc_stop) stop_cnt_r <= 7'h00;
		else if (clk_en) stop_cnt_r <= stop_cnt_r + 7'h01;
	end

	property p_write_quiet; (!write_enable_n)[*3] |-> !$rose(read_pulse); endproperty
	property p_pulse_len; $rose(read_pulse) |-> read_pulse[*4]; endproperty
	property p_read_tag; tag_ctrl |=> read_gate_r == $past(ctrl_bus[1]); endproperty
	property p_mark_tag;
		tag_ctrl |=> address_mark_gate_n == !($past(ctrl_bus[1]) && $past(ctrl_bus[5]));
	endproperty
	property p_early; tag_ctrl && ctrl_bus[7] && !ctrl_bus[8] |=> strobe_early_r && !strobe_late_r; endproperty
	property p_late; tag_ctrl && ctrl_bus[8] && !ctrl_bus[7] |=> strobe_late_r && !strobe_early_r; endproperty
	property p_hold; !tag_ctrl |=> $stable({read_gate_r, address_mark_gate_n}); endproperty
	property p_stop_len; $fell(osc_stop) |-> stop_cnt_r == 7'h28; endproperty
	property p_pump_down;
		$rose(pump_down) && read_gate_r && address_mark_gate_n |-> pump_down[*2] ##1 !pump_down;
	endproperty
	property p_relock; $changed(read_gate_r) |-> ##[1:405] locked; endproperty

	a_write_quiet: assert property (p_write_quiet) else $error("read pulse while writing");
	a_pulse_len: assert property (p_pulse_len) else $error("read pulse too short");
	a_read_tag: assert property (p_read_tag) else $error("read gate not set by tag");
	a_mark_tag: assert property (p_mark_tag) else $error("mark gate wrong after tag");
	a_early: assert property (p_early) else $error("early strobe not latched");
	a_late: assert property (p_late) else $error("late strobe not latched");
	a_hold: assert property (p_hold) else $error("gates moved without a tag");
	a_stop_len: assert property (p_stop_len) else $error("stop pulse length wrong");
	a_pump_down: assert property (p_pump_down) else $error("pump down length wrong");
	a_relock: assert property (p_relock) else $error("no lock after switch");

	c_pulse: cover property ($rose(read_pulse));
	c_mark_pulse: cover property (!address_mark_gate_n && $rose(read_pulse));
	c_stop: cover property ($fell(osc_stop));
	c_lock: cover property ($rose(locked));
endmodule // rpq_checker

bind rpq_core rpq_checker u_chk (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
	.write_enable_n(write_enable_n), .tag_ctrl(tag_ctrl), .ctrl_bus(ctrl_bus),
	.read_pulse(read_pulse), .address_mark_gate_n(address_mark_gate_n),
	.read_gate_r(read_gate_r), .pump_down(pump_down), .osc_stop(osc_stop),
	.locked(locked), .strobe_early_r(strobe_early_r), .strobe_late_r(strobe_late_r));

// file: sim/rpq_ctrl_model.sv
/* Disk controller model that issues control-select tags on the bus.
   Assumes the bench calls send from its main sequence, one tag at a time. */
`timescale 1ns/1ps
`include "rpq_defs.vh"
module rpq_ctrl_model (
	input  wire logic                  clock,
	output logic                       tag_ctrl,
	output logic [`RPQ_BUS_W-1:0]      ctrl_bus
);
	// Between tags the bus is driven, all ones at start and then the inverse of the last tag.
	initial begin
		tag_ctrl = 1'b0;
		ctrl_bus = 10'h3FF;
	end

	// Issues one tag cycle; afterwards the bus shows the inverse value.
	task automatic send(input logic [`RPQ_BUS_W-1:0] b);
		@(posedge clock);
		#1;
		tag_ctrl = 1'b1;
		ctrl_bus = b;
		@(posedge clock);
		#1;
		tag_ctrl = 1'b0;
		ctrl_bus = ~b;
	endtask
endmodule // rpq_ctrl_model

// file: sim/testbench.sv
/* Self-checking bench for rpq_core: read path, mark search, loop and strobes.
   Assumes the controller model and the checker bound to the core. */
`timescale 1ns/1ps
`include "rpq_defs.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
	$display("MISMATCH at %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
	logic clock = 1'b0, rst_n, clk_en, write_enable_n, low_res, high_res_clk, osc_run = 1'b0;
	logic double_rate_read_osc, write_side_reference, data_ready, tag_ctrl;
	logic [`RPQ_BUS_W-1:0] ctrl_bus;
	logic read_pulse, address_mark_gate_n, read_gate_r, pump_up, pump_down, osc_stop, locked;
	logic read_clock_out, clocked_data, data_valid, fifo_ready, strobe_early_r, strobe_late_r;
	logic rp_q = 1'b0, up_q = 1'b0, dn_q = 1'b0, st_q = 1'b0; // Previous output levels.
	int failures = 0, n_tests = 0, npulse = 0, nup = 0, ndn = 0, nstop = 0, p0, u0, d0, s0, k, ones;

	always #2.5 clock = ~clock;

	rpq_ctrl_model ctl (.clock(clock), .tag_ctrl(tag_ctrl), .ctrl_bus(ctrl_bus));
	rpq_core dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .write_enable_n(write_enable_n),
		.low_res(low_res), .high_res_clk(high_res_clk), .tag_ctrl(tag_ctrl), .ctrl_bus(ctrl_bus),
		.double_rate_read_osc(double_rate_read_osc), .write_side_reference(write_side_reference),
		.data_ready(data_ready), .read_pulse(read_pulse), .address_mark_gate_n(address_mark_gate_n),
		.read_gate_r(read_gate_r), .pump_up(pump_up), .pump_down(pump_down), .osc_stop(osc_stop),
		.locked(locked), .read_clock_out(read_clock_out), .clocked_data(clocked_data),
		.data_valid(data_valid), .fifo_ready(fifo_ready), .strobe_early_r(strobe_early_r),
		.strobe_late_r(strobe_late_r));

	// Counts rising edges of the pulse outputs.
	always @(posedge clock) begin
		rp_q <= read_pulse;
		up_q <= pump_up;
		dn_q <= pump_down;
		st_q <= osc_stop;
		if (read_pulse === 1'b1 && rp_q !== 1'b1) npulse++;
		if (pump_up === 1'b1 && up_q !== 1'b1) nup++;
		if (pump_down === 1'b1 && dn_q !== 1'b1) ndn++;
		if (osc_stop === 1'b1 && st_q !== 1'b1) nstop++;
	end

	// Free-running oscillator when enabled, toggled just after each edge.
	always begin
		@(posedge clock);
		#1;
		if (osc_run) double_rate_read_osc = ~double_rate_read_osc;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// One flux event: optional low-res change, then a delayed high-res clock.
	task automatic flux(input logic chg);
		if (chg) low_res = ~low_res;
		tick(1);
		high_res_clk = 1'b1;
		tick(1);
		high_res_clk = 1'b0;
		tick(8);
	endtask

	// Idle comparator: reference leads or lags the oscillator by three cycles.
	task automatic cmp(input logic lead);
		u0 = nup;
		d0 = ndn;
		if (lead) write_side_reference = 1'b1; else double_rate_read_osc = 1'b1;
		tick(3);
		write_side_reference = 1'b1;
		double_rate_read_osc = 1'b1;
		tick(8);
		write_side_reference = 1'b0;
		double_rate_read_osc = 1'b0;
		tick(4);
		`CHK(nup > u0, lead)
		`CHK(ndn > d0, !lead)
	endtask

	// Sends a strobe tag and measures the clock delay in cycles.
	task automatic strobe(input logic [`RPQ_BUS_W-1:0] b, input int n);
		ctl.send(b);
		tick(3);
		double_rate_read_osc = 1'b1;
		k = 0;
		while (read_clock_out !== 1'b1 && k < 5) begin
			tick(1);
			k++;
		end
		`CHK(k, n)
		double_rate_read_osc = 1'b0;
		tick(3);
	endtask

	task automatic results;
		$display("failures=%0d n_tests=%0d", failures, n_tests);
		if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		#100000;
		failures++;
		results;
	end

	initial begin
		rst_n = 1'b0; clk_en = 1'b1; write_enable_n = 1'b1; low_res = 1'b0; high_res_clk = 1'b0;
		double_rate_read_osc = 1'b0; write_side_reference = 1'b0; data_ready = 1'b0;
		tick(10);
		rst_n = 1'b1;
		tick(1);
		`CHK(address_mark_gate_n, 1'b1)
		p0 = npulse;
		flux(1'b1);
		`CHK(npulse - p0, 0)
		// The flop ignored that change, so put the channel back to match it.
		low_res = ~low_res;
		ctl.send(10'h002);
		`CHK(read_gate_r, 1'b1)
		p0 = npulse;
		s0 = nstop;
		flux(1'b1);
		`CHK(npulse - p0, 1)
		`CHK(nstop - s0, 1)
		flux(1'b0);
		`CHK(npulse - p0, 1)
		tick(410);
		`CHK(locked, 1'b1)
		osc_run = 1'b1;
		u0 = nup;
		d0 = ndn;
		flux(1'b1);
		`CHK(nup > u0, 1'b1)
		`CHK(ndn > d0, 1'b1)
		write_side_reference = 1'b0;
		write_enable_n = 1'b0;
		p0 = npulse;
		flux(1'b1);
		flux(1'b1);
		`CHK(npulse - p0, 0)
		write_enable_n = 1'b1;
		repeat (20) flux(1'b1);
		`CHK(fifo_ready, 1'b0)
		osc_run = 1'b0;
		data_ready = 1'b1;
		k = 0;
		ones = 0;
		while (data_valid !== 1'b0 && k < 60) begin
			if (clocked_data === 1'b1) ones++;
			tick(1);
			k++;
		end
		`CHK(ones >= 2, 1'b1)
		`CHK(data_valid, 1'b0)
		`CHK(fifo_ready, 1'b1)
		ctl.send(10'h022);
		`CHK(address_mark_gate_n, 1'b0)
		p0 = npulse;
		low_res = ~low_res;
		tick(8);
		`CHK(npulse - p0, 1)
		flux(1'b0);
		tick(40);
		`CHK(npulse - p0, 1)
		ctl.send(10'h000);
		double_rate_read_osc = 1'b0;
		tick(50);
		cmp(1'b1);
		cmp(1'b0);
		strobe(10'h002, 1);
		strobe(10'h082, 2);
		// A frozen cycle must ignore a tag that would clear the read gate.
		clk_en = 1'b0;
		ctl.send(10'h000);
		`CHK(read_gate_r, 1'b1)
		clk_en = 1'b1;
		strobe(10'h102, 1);
		`CHK(strobe_late_r, 1'b1)
		strobe(10'h182, 1);
		results;
	end
endmodule // testbench
